//--- logic/dhm_mem_if.sv
`include "dhm_cfg.svh"
`default_nettype none
// ==========================================================
// Contract
// R1: program port drives 24-bit word address
// R2: program data 48 bits, 40-bit drops 8
// R3: 32-bit program data ignores low 16
// R4: data port drives 32-bit word address
// R5: data path 40 bits, 32-bit drops 8
// R6: four data bank selects from address
// R7: two program bank selects from address
// R8: per-bank wait states zero to seven
// R9: lengthen by waits and/or acknowledge
// R10: both ports mark page crossings
// R11: data address direct or from generator
// R12: both generators may issue same cycle
// R13: bus request halts, floats, then grants
// R14: port float stalls only that port
// R15: bridge register joins program and data
// R16: colliding fetch served from 32-entry cache
// R17: outside lowers ack to add waits
// R18: outside holds ack after float release
// R19: page output on program page crossing
// R20: finish access before grant, hold till withdrawn
module dhm_mem_if
    import dhm_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // program port data requests
    input wire logic pm_req_valid,
    output logic pm_req_ready,
    input wire logic pm_req_write,
    input wire dhm_fmt_t pm_req_fmt,
    input wire logic [`DHM_PA_W-1:0] prog_addr_gen,
    input wire logic [`DHM_PD_W-1:0] pm_wdata,
    // instruction fetch
    input wire logic fetch_valid,
    output logic fetch_ready,
    input wire logic [`DHM_PA_W-1:0] fetch_addr,
    output logic fetch_done,
    output logic [`DHM_PD_W-1:0] fetch_instr,
    // data port requests
    input wire logic dm_req_valid,
    output logic dm_req_ready,
    input wire logic dm_req_write,
    input wire dhm_fmt_t dm_req_fmt,
    input wire logic dm_direct,
    input wire logic [`DHM_DA_W-1:0] dm_abs_addr,
    input wire logic [`DHM_DA_W-1:0] data_addr_gen,
    input wire logic [`DHM_DD_W-1:0] dm_wdata,
    // read data stream
    output logic rd_valid,
    input wire logic rd_ready,
    output logic rd_port,
    output logic [`DHM_PD_W-1:0] rd_data,
    // bridge register
    input wire logic bridge_load,
    input wire dhm_br_t bridge_src,
    input wire logic [`DHM_DD_W-1:0] bridge_rf_data,
    output logic [`DHM_PD_W-1:0] port_bridge_reg,
    // configuration
    input wire logic [`DHM_PBANKS-1:0][`DHM_WS_W-1:0] prog_wait,
    input wire logic [`DHM_DBANKS-1:0][`DHM_WS_W-1:0] data_wait,
    input wire dhm_ack_t prog_ack_mode,
    input wire dhm_ack_t data_ack_mode,
    input wire logic [`DHM_PA_W-1:0] prog_bank_bound,
    input wire logic [2:0][`DHM_DA_W-1:0] data_bank_bound,
    input wire logic [4:0] prog_page_bits,
    input wire logic [4:0] data_page_bits,
    // status
    output logic core_halt,
    // program memory pins
    output logic [`DHM_PA_W-1:0] prog_addr_bus,
    input wire logic [`DHM_PD_W-1:0] prog_data_bus_i,
    output logic [`DHM_PD_W-1:0] prog_data_bus_o,
    output logic prog_data_bus_oe,
    output logic prog_ctl_oe,
    output logic [`DHM_PBANKS-1:0] prog_bank_select_n,
    output logic prog_rd_n,
    output logic prog_wr_n,
    input wire logic prog_access_ack,
    input wire logic prog_port_float_n,
    output logic prog_page_cross,
    // data memory pins
    output logic [`DHM_DA_W-1:0] data_addr_bus,
    input wire logic [`DHM_DD_W-1:0] data_data_bus_i,
    output logic [`DHM_DD_W-1:0] data_data_bus_o,
    output logic data_data_bus_oe,
    output logic data_ctl_oe,
    output logic [`DHM_DBANKS-1:0] data_bank_select_n,
    output logic data_rd_n,
    output logic data_wr_n,
    input wire logic data_access_ack,
    input wire logic data_port_float_n,
    output logic data_page_cross,
    // bus arbitration
    input wire logic bus_request_n,
    output logic bus_grant_n
);
    // ==========================================================
    // helpers
    function automatic logic [`DHM_PD_W-1:0] fmask(input logic dm, input dhm_fmt_t f);
        logic [`DHM_PD_W-1:0] m;
        m = '1;
        if (dm) begin
            m = {8'h00, {`DHM_DD_W{1'b1}}};
            if (f == DHM_FMT_32) m[`DHM_DM32_LO-1:0] = '0;
        end else if (f == DHM_FMT_40) m[`DHM_PM40_LO-1:0] = '0;
        else if (f == DHM_FMT_32) m[`DHM_PM32_LO-1:0] = '0;
        return m;
    endfunction

    function automatic logic [1:0] dbank(input logic [31:0] a, input logic [2:0][31:0] b);
        return 2'(a >= b[0]) + 2'(a >= b[1]) + 2'(a >= b[2]);
    endfunction

    function automatic logic [3:0] onehot(input logic [1:0] b);
        return 4'h1 << b;
    endfunction

    function automatic logic [31:0] page(input logic [31:0] a, input logic [4:0] s);
        return a >> s;
    endfunction

    // ==========================================================
    // pin synchronisers
    logic [1:0] ack_s1, ack_s2, flt_s1, flt_s2;
    logic br_s1, br_s2;
    logic [`DHM_PD_W-1:0] pd_s1, pd_s2;
    logic [`DHM_DD_W-1:0] dd_s1, dd_s2;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ack_s1 <= '0;
            ack_s2 <= '0;
            flt_s1 <= 2'h3;
            flt_s2 <= 2'h3;
            br_s1 <= 1'b1;
            br_s2 <= 1'b1;
        end else begin
            ack_s1 <= {data_access_ack, prog_access_ack};
            ack_s2 <= ack_s1;
            flt_s1 <= {data_port_float_n, prog_port_float_n};
            flt_s2 <= flt_s1;
            br_s1 <= bus_request_n;
            br_s2 <= br_s1;
        end
    end
    // data buses need no reset
    always_ff @(posedge sys_clk) begin
        pd_s1 <= prog_data_bus_i;
        pd_s2 <= pd_s1;
        dd_s1 <= data_data_bus_i;
        dd_s2 <= dd_s1;
    end

    // ==========================================================
    // request selection and decode
    wire logic [1:0] flt;
    wire logic breq;
    logic gnt;
    wire logic [`DHM_DA_W-1:0] dm_addr;
    wire logic [31:0] nb_addr [2];
    wire logic [`DHM_PD_W-1:0] nb_wdata [2];
    wire logic [`DHM_PD_W-1:0] din [2];
    wire logic [1:0] nb_bank [2];
    wire logic [2:0] nb_ws [2];
    wire dhm_ack_t nb_mode [2];
    wire logic [4:0] pg_bits [2];
    wire dhm_fmt_t nb_fmt [2];
    wire logic [1:0] eng_req, nb_wr, can, go, done_ev;
    dhm_st_t st [2];
    logic [`DHM_CNT_W-1:0] cnt [2];
    logic [31:0] a_addr [2];
    logic [`DHM_PD_W-1:0] a_wdata [2];
    logic [`DHM_PD_W-1:0] rdat [2];
    logic [1:0] a_bank [2];
    logic [2:0] a_ws [2];
    logic [1:0] a_wr, a_ack, a_px;
    dhm_fmt_t a_fmt [2];
    logic a_fetch, a_fill, fill_pend;
    logic [1:0] pushed;
    wire logic hit, cache_srv;

    assign flt = ~flt_s2;
    assign breq = !br_s2;
    assign core_halt = gnt || breq; // R13
    assign dm_addr = dm_direct ? dm_abs_addr : data_addr_gen; // R11
    // pm data beats the fetch
    assign nb_addr[0] = {8'h00, (pm_req_valid ? prog_addr_gen : fetch_addr)}; // R12
    assign nb_addr[1] = dm_addr; // R12
    assign nb_wdata[0] = pm_wdata;
    assign nb_wdata[1] = {8'h00, dm_wdata};
    assign din[0] = pd_s2;
    assign din[1] = {8'h00, dd_s2};
    assign nb_fmt[0] = pm_req_valid ? pm_req_fmt : DHM_FMT_FULL;
    assign nb_fmt[1] = dm_req_fmt;
    assign nb_bank[0] = {1'b0, nb_addr[0][`DHM_PA_W-1:0] >= prog_bank_bound}; // R7
    assign nb_bank[1] = dbank(dm_addr, data_bank_bound); // R6
    assign nb_ws[0] = prog_wait[nb_bank[0][0]]; // R8
    assign nb_ws[1] = data_wait[nb_bank[1]]; // R8
    assign nb_mode[0] = prog_ack_mode;
    assign nb_mode[1] = data_ack_mode;
    assign pg_bits[0] = prog_page_bits;
    assign pg_bits[1] = data_page_bits;
    assign nb_wr = {dm_req_write, pm_req_valid && pm_req_write};
    assign eng_req = {dm_req_valid, pm_req_valid || (fetch_valid && !cache_srv)};
    // float stalls own port only
    assign can[0] = (st[0] == DHM_IDLE) && !core_halt && !flt[0]; // R14
    assign can[1] = (st[1] == DHM_IDLE) && !core_halt && !flt[1]; // R14
    assign go = eng_req & can;
    assign pm_req_ready = can[0];
    assign dm_req_ready = can[1];
    assign fetch_ready = cache_srv || (can[0] && !pm_req_valid);

    // ==========================================================
    // port engines
    generate
        for (genvar p = 0; p < 2; p++) begin : g_eng
            assign done_ev[p] = (st[p] == DHM_STROBE) && !flt[p] && (cnt[p] == '0)
                && (!a_ack[p] || ack_s2[p]); // R9
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    st[p] <= DHM_IDLE;
                    cnt[p] <= '0;
                    a_addr[p] <= '0;
                    a_wdata[p] <= '0;
                    a_wr[p] <= 1'b0;
                    a_ack[p] <= 1'b0;
                    a_px[p] <= 1'b0;
                    a_bank[p] <= '0;
                    a_ws[p] <= '0;
                    a_fmt[p] <= DHM_FMT_FULL;
                    rdat[p] <= '0;
                end else if (go[p]) begin
                    st[p] <= DHM_STROBE;
                    a_addr[p] <= nb_addr[p]; // R1 R4
                    a_wdata[p] <= nb_wdata[p] & fmask(p[0], nb_fmt[p]); // R2 R3 R5
                    a_wr[p] <= nb_wr[p];
                    a_fmt[p] <= nb_fmt[p];
                    a_bank[p] <= nb_bank[p];
                    a_ws[p] <= nb_ws[p];
                    a_ack[p] <= (nb_mode[p] != DHM_WS_ONLY); // R9
                    // waits, then sync lag
                    cnt[p] <= (nb_mode[p] == DHM_ACK_ONLY) ? `DHM_CNT_W'(`DHM_SYNC_CYC)
                        : `DHM_CNT_W'(nb_ws[p]) + `DHM_CNT_W'(`DHM_SYNC_CYC); // R8 R9
                    a_px[p] <= page(nb_addr[p], pg_bits[p]) != page(a_addr[p], pg_bits[p]); // R10
                end else if (st[p] == DHM_STROBE && !flt[p]) begin // R14
                    if (cnt[p] != '0) cnt[p] <= cnt[p] - 1'b1;
                    if (done_ev[p]) begin
                        rdat[p] <= din[p] & fmask(p[0], a_fmt[p]); // R2 R3 R5
                        st[p] <= (a_wr[p] || (p == 0 && a_fetch)) ? DHM_IDLE : DHM_DONE;
                    end
                end else if (st[p] == DHM_DONE && pushed[p]) begin
                    st[p] <= DHM_IDLE;
                end
            end
        end
    endgenerate

    // ==========================================================
    // read fifo; when full, engines wait in done
    dhm_stream_if #(.W(`DHM_FIFO_W)) rd_in ();
    dhm_stream_if #(.W(`DHM_FIFO_W)) rd_out ();
    assign rd_in.valid = (st[0] == DHM_DONE) || (st[1] == DHM_DONE);
    assign rd_in.data = (st[0] == DHM_DONE) ? {1'b0, rdat[0]} : {1'b1, rdat[1]};
    assign pushed[0] = (st[0] == DHM_DONE) && rd_in.ready;
    assign pushed[1] = (st[1] == DHM_DONE) && (st[0] != DHM_DONE) && rd_in.ready;
    assign rd_valid = rd_out.valid;
    assign rd_out.ready = rd_ready;
    assign rd_port = rd_out.data[`DHM_FIFO_W-1];
    assign rd_data = rd_out.data[`DHM_PD_W-1:0];
    dhm_fifo #(.W(`DHM_FIFO_W), .DEPTH(`DHM_FIFO_DEPTH)) u_rd_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .fill(rd_in),
        .drain(rd_out)
    );

    // ==========================================================
    // fetch cache, 2 ways x 16 sets
    logic c_val [`DHM_C_SETS][2];
    logic [`DHM_C_TAG_W-1:0] c_tag [`DHM_C_SETS][2];
    logic [`DHM_PD_W-1:0] c_dat [`DHM_C_SETS][2];
    logic c_lru [`DHM_C_SETS];
    wire logic [`DHM_C_IDX_W-1:0] f_idx, w_idx;
    wire logic [`DHM_C_TAG_W-1:0] f_tag;
    wire logic hit1, fill_ev, w_way;
    assign f_idx = fetch_addr[`DHM_C_IDX_W-1:0];
    assign f_tag = fetch_addr[`DHM_PA_W-1:`DHM_C_IDX_W];
    assign hit1 = c_val[f_idx][1] && (c_tag[f_idx][1] == f_tag);
    assign hit = hit1 || (c_val[f_idx][0] && (c_tag[f_idx][0] == f_tag));
    assign cache_srv = fetch_valid && hit && !core_halt; // R16
    assign w_idx = a_addr[0][`DHM_C_IDX_W-1:0];
    assign w_way = !c_val[w_idx][0] ? 1'b0 : !c_val[w_idx][1] ? 1'b1 : c_lru[w_idx];
    assign fill_ev = done_ev[0] && a_fetch && a_fill;

    // only colliding fetches are cached
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < `DHM_C_SETS; i++) begin
                c_val[i][0] <= 1'b0;
                c_val[i][1] <= 1'b0;
                c_lru[i] <= 1'b0;
            end
            fill_pend <= 1'b0;
            a_fetch <= 1'b0;
            a_fill <= 1'b0;
        end else begin
            if (fetch_valid && pm_req_valid && !hit) fill_pend <= 1'b1; // R16
            else if (go[0] && !pm_req_valid) fill_pend <= 1'b0;
            if (go[0]) begin
                a_fetch <= !pm_req_valid;
                a_fill <= fill_pend;
            end
            if (cache_srv) c_lru[f_idx] <= !hit1;
            if (fill_ev) begin // R16
                c_val[w_idx][w_way] <= 1'b1;
                c_tag[w_idx][w_way] <= a_addr[0][`DHM_PA_W-1:`DHM_C_IDX_W];
                c_dat[w_idx][w_way] <= din[0];
                c_lru[w_idx] <= !w_way;
            end
        end
    end

    // fetch result
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fetch_done <= 1'b0;
            fetch_instr <= '0;
        end else begin
            fetch_done <= cache_srv || (done_ev[0] && a_fetch);
            if (cache_srv) fetch_instr <= c_dat[f_idx][hit1]; // R16
            else if (done_ev[0] && a_fetch) fetch_instr <= din[0];
        end
    end

    // ==========================================================
    // bridge, 40-bit in upper bits
    always_ff @(posedge sys_clk) begin
        if (rst) port_bridge_reg <= '0;
        else if (bridge_load) begin
            case (bridge_src)
                DHM_BR_PM: port_bridge_reg <= rdat[0]; // R15
                DHM_BR_DM: port_bridge_reg <= {rdat[1][`DHM_DD_W-1:0], 8'h00}; // R15
                DHM_BR_RF: port_bridge_reg <= {bridge_rf_data, 8'h00}; // R15
                default: port_bridge_reg <= port_bridge_reg;
            endcase
        end
    end

    // ==========================================================
    // grant once no strobe open
    always_ff @(posedge sys_clk) begin
        if (rst) gnt <= 1'b0;
        else if (!gnt && breq && st[0] != DHM_STROBE && st[1] != DHM_STROBE) gnt <= 1'b1; // R20
        else if (gnt && !breq) gnt <= 1'b0; // R20
    end

    // ==========================================================
    // pin drive
    wire logic [1:0] stb;
    wire logic [3:0] psel_oh;
    assign stb = {st[1] == DHM_STROBE, st[0] == DHM_STROBE};
    assign psel_oh = onehot(a_bank[0]);
    assign bus_grant_n = !gnt;
    assign prog_ctl_oe = !gnt && !flt[0]; // R13 R14
    assign data_ctl_oe = !gnt && !flt[1]; // R13 R14
    assign prog_data_bus_oe = prog_ctl_oe && stb[0] && a_wr[0];
    assign data_data_bus_oe = data_ctl_oe && stb[1] && a_wr[1];
    assign prog_addr_bus = a_addr[0][`DHM_PA_W-1:0]; // R1
    assign data_addr_bus = a_addr[1]; // R4
    assign prog_data_bus_o = a_wdata[0];
    assign data_data_bus_o = a_wdata[1][`DHM_DD_W-1:0];
    assign prog_bank_select_n = ~(stb[0] ? psel_oh[1:0] : 2'h0); // R7
    assign data_bank_select_n = ~(stb[1] ? onehot(a_bank[1]) : 4'h0); // R6
    assign prog_rd_n = !(stb[0] && !a_wr[0]);
    assign prog_wr_n = !(stb[0] && a_wr[0]);
    assign data_rd_n = !(stb[1] && !a_wr[1]);
    assign data_wr_n = !(stb[1] && a_wr[1]);
    assign prog_page_cross = stb[0] && a_px[0]; // R19
    assign data_page_cross = stb[1] && a_px[1]; // R10

    // ==========================================================
    // assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [4:0] slen0;
    always_ff @(posedge sys_clk) begin
        if (rst || go[0]) slen0 <= '0;
        else if (stb[0] && slen0 != 5'h1f) slen0 <= slen0 + 1'b1;
    end
    property p_grant_idle;
        !gnt ##1 gnt |-> !stb[0] && !stb[1] && $past(!stb[0] && !stb[1]);
    endproperty
    a_grant_idle: assert property (p_grant_idle) else $error("grant during access"); // R20
    property p_grant_float;
        gnt |-> !prog_ctl_oe && !data_ctl_oe && !pm_req_ready && !dm_req_ready;
    endproperty
    a_grant_float: assert property (p_grant_float) else $error("granted bus driven"); // R13
    property p_grant_hold;
        gnt && breq |=> gnt;
    endproperty
    a_grant_hold: assert property (p_grant_hold) else $error("grant dropped early"); // R20
    property p_float_stall;
        flt[0] && stb[0] |=> stb[0] && $stable(cnt[0]) && !prog_ctl_oe;
    endproperty
    a_float_stall: assert property (p_float_stall) else $error("floated port moved"); // R14
    property p_wait_len;
        done_ev[0] && !a_ack[0] |-> slen0 == 5'(a_ws[0]) + 5'd2;
    endproperty
    a_wait_len: assert property (p_wait_len) else $error("wait count wrong"); // R8
    property p_ack_wait;
        stb[1] && cnt[1] == '0 && a_ack[1] && !ack_s2[1] && !flt[1] |=> stb[1];
    endproperty
    a_ack_wait: assert property (p_ack_wait) else $error("ack ignored"); // R9
    property p_page;
        go[0] && page(nb_addr[0], prog_page_bits) != page(a_addr[0], prog_page_bits)
            |=> prog_page_cross;
    endproperty
    a_page: assert property (p_page) else $error("page cross missed"); // R19
    property p_dsel;
        $countones(~data_bank_select_n) <= 1 && (stb[1] -> !data_bank_select_n[a_bank[1]]);
    endproperty
    a_dsel: assert property (p_dsel) else $error("data select wrong"); // R6
    property p_psel;
        stb[0] |-> prog_bank_select_n == ~psel_oh[1:0];
    endproperty
    a_psel: assert property (p_psel) else $error("prog select wrong"); // R7
    property p_cache;
        fetch_valid && pm_req_valid && hit && !core_halt |=> fetch_done;
    endproperty
    a_cache: assert property (p_cache) else $error("cache hit not served"); // R16
    property p_mask32;
        done_ev[0] && !a_wr[0] && a_fmt[0] == DHM_FMT_32 |=> rdat[0][15:0] == 16'h0000;
    endproperty
    a_mask32: assert property (p_mask32) else $error("low bits kept"); // R3
    c_grant: cover property (gnt ##1 !gnt);
    c_hit: cover property (cache_srv && pm_req_valid);
    c_both: cover property (go[0] && go[1]);
    c_full: cover property (!rd_in.ready);
endmodule
`default_nettype wire

//--- logic/dhm_cfg.svh
`ifndef DHM_CFG_SVH
`define DHM_CFG_SVH
// ==========================================================
// bus widths
`define DHM_PA_W 24
`define DHM_PD_W 48
`define DHM_DA_W 32
`define DHM_DD_W 40
// unused low bits
`define DHM_PM40_LO 8
`define DHM_PM32_LO 16
`define DHM_DM32_LO 8
// ==========================================================
// banks and wait states
`define DHM_PBANKS 2
`define DHM_DBANKS 4
`define DHM_WS_W 3
`define DHM_CNT_W 4
// ==========================================================
// timing
`define DHM_CLK_NS 10
`define DHM_SYNC_CYC 2
// ==========================================================
// buffering and cache
`define DHM_FIFO_DEPTH 32
`define DHM_FIFO_W 49
`define DHM_C_SETS 16
`define DHM_C_IDX_W 4
`define DHM_C_TAG_W 20
`endif

//--- logic/dhm_pkg.sv
`default_nettype none
package dhm_pkg;
    // transfer format on a data path
    typedef enum logic [1:0] {DHM_FMT_FULL, DHM_FMT_40, DHM_FMT_32} dhm_fmt_t;
    // how an access is lengthened
    typedef enum logic [1:0] {DHM_WS_ONLY, DHM_ACK_ONLY, DHM_WS_AND_ACK} dhm_ack_t;
    // source of the bridge register
    typedef enum logic [1:0] {DHM_BR_PM, DHM_BR_DM, DHM_BR_RF} dhm_br_t;
    // port engine state
    typedef enum logic [1:0] {DHM_IDLE, DHM_STROBE, DHM_DONE} dhm_st_t;
endpackage
`default_nettype wire

//--- logic/dhm_stream_if.sv
`default_nettype none
interface dhm_stream_if #(parameter int W = 8) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- logic/dhm_fifo.sv
`default_nettype none
// ==========================================================
// fifo, depth a power of two
module dhm_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // filling and draining sides
    dhm_stream_if.snk fill,
    dhm_stream_if.src drain
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    wire logic do_wr;
    wire logic do_rd;

    // flags from the fill count
    assign fill.ready = (cnt != (AW+1)'(DEPTH));
    assign drain.valid = (cnt != '0);
    assign drain.data = mem[rp];
    assign do_wr = fill.valid && fill.ready;
    assign do_rd = drain.valid && drain.ready;

    // storage, not reset
    always_ff @(posedge sys_clk) begin
        if (do_wr) begin
            mem[wp] <= fill.data;
        end
    end

    // pointers wrap at power of two
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            if (do_wr) wp <= wp + 1'b1;
            if (do_rd) rp <= rp + 1'b1;
            if (do_wr && !do_rd) cnt <= cnt + 1'b1;
            else if (do_rd && !do_wr) cnt <= cnt - 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- dv/dhm_mem_model.sv
`default_nettype none
// ==========================================================
// far side: sixteen words on each port
module dhm_mem_model (
    // clock
    input wire logic sys_clk,
    // program pins
    input wire logic [23:0] prog_addr_bus,
    input wire logic [47:0] prog_data_bus_o,
    input wire logic prog_rd_n,
    input wire logic prog_wr_n,
    output logic [47:0] prog_data_bus_i,
    output logic prog_access_ack,
    // data pins
    input wire logic [31:0] data_addr_bus,
    input wire logic [39:0] data_data_bus_o,
    input wire logic data_rd_n,
    input wire logic data_wr_n,
    output logic [39:0] data_data_bus_i,
    output logic data_access_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [47:0] pm [16];
    logic [39:0] dm [16];
    // store while the write strobe is low
    always @(posedge sys_clk) begin
        if (!prog_wr_n) pm[prog_addr_bus[3:0]] <= prog_data_bus_o;
        if (!data_wr_n) dm[data_addr_bus[3:0]] <= data_data_bus_o;
    end
    // released bus shows the inverse
    assign prog_data_bus_i = prog_rd_n ? ~pm[prog_addr_bus[3:0]] : pm[prog_addr_bus[3:0]];
    assign data_data_bus_i = data_rd_n ? ~dm[data_addr_bus[3:0]] : dm[data_addr_bus[3:0]];
    // always ready
    assign prog_access_ack = 1'h1;
    assign data_access_ack = 1'h1;
endmodule
`default_nettype wire

//--- dv/dual_harvard_memory_interface_tb_top.sv
`default_nettype none
// ==========================================================
// bench top
module dual_harvard_memory_interface_tb_top
    import dhm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst = 1, rd_ready = 0, bus_request_n = 1, bridge_load = 0, dm_direct = 0;
    logic prog_port_float_n = 1, data_port_float_n = 1, fetch_valid = 0;
    logic pm_req_valid = 0, pm_req_write = 0, dm_req_valid = 0, dm_req_write = 0;
    logic pm_req_ready, dm_req_ready, fetch_ready, fetch_done, rd_valid, rd_port, core_halt;
    logic prog_data_bus_oe, prog_ctl_oe, prog_rd_n, prog_wr_n, prog_access_ack, prog_page_cross;
    logic data_data_bus_oe, data_ctl_oe, data_rd_n, data_wr_n, data_access_ack, data_page_cross;
    logic bus_grant_n;
    dhm_fmt_t pm_req_fmt = DHM_FMT_FULL, dm_req_fmt = DHM_FMT_FULL;
    dhm_ack_t prog_ack_mode = DHM_WS_ONLY, data_ack_mode = DHM_WS_ONLY;
    dhm_br_t bridge_src = DHM_BR_RF;
    logic [23:0] prog_addr_gen = 0, fetch_addr = 0, prog_bank_bound = 24'h800000, prog_addr_bus;
    logic [31:0] dm_abs_addr = 0, data_addr_gen = 0, data_addr_bus;
    logic [47:0] pm_wdata = 0, fetch_instr, rd_data, port_bridge_reg;
    logic [47:0] prog_data_bus_i, prog_data_bus_o;
    logic [39:0] dm_wdata = 0, bridge_rf_data = 0, data_data_bus_i, data_data_bus_o;
    logic [1:0][2:0] prog_wait = 6'h0b;
    logic [3:0][2:0] data_wait = 12'hf50;
    logic [2:0][31:0] data_bank_bound = {32'h30000000, 32'h20000000, 32'h10000000};
    logic [4:0] prog_page_bits = 5'h04, data_page_bits = 5'h04;
    logic [1:0] prog_bank_select_n, psel;
    logic [3:0] data_bank_select_n, dsel;
    int dlen, cyc, fails, total_checks;
    dhm_mem_if dut (.*);
    dhm_mem_model mem (.*);
    // clock, limit, capture
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            wrap_up();
        end
        if (!prog_rd_n) psel <= prog_bank_select_n;
        if (!data_rd_n) dsel <= data_bank_select_n;
        if (!data_rd_n) dlen <= dlen + 1;
    end
    // ==========================================================
    // helpers
    task chk(string n, logic [47:0] e, logic [47:0] s);
        total_checks++;
        if (e !== s) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task wrap_up();
        if (fails == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // held until taken
    task pm_op(logic w, dhm_fmt_t f, logic [23:0] a, logic [47:0] d);
        @(posedge sys_clk);
        {pm_req_valid, pm_req_write, pm_req_fmt, prog_addr_gen, pm_wdata} <= {1'h1, w, f, a, d};
        do @(negedge sys_clk); while (!pm_req_ready);
        @(posedge sys_clk) pm_req_valid <= 1'h0;
    endtask
    // unused source gets the inverse
    task dm_op(logic w, dhm_fmt_t f, logic dir, logic [31:0] a, logic [39:0] d);
        @(posedge sys_clk);
        {dm_req_valid, dm_req_write, dm_req_fmt, dm_direct, dm_wdata} <= {1'h1, w, f, dir, d};
        dm_abs_addr <= dir ? a : ~a;
        data_addr_gen <= dir ? ~a : a;
        do @(negedge sys_clk); while (!dm_req_ready);
        @(posedge sys_clk) dm_req_valid <= 1'h0;
    endtask
    task get_rd(logic [47:0] e, logic p);
        do @(negedge sys_clk); while (!rd_valid);
        chk("rd_data", e, p ? {8'h0, rd_data[39:0]} : rd_data);
        chk("rd_port", p, rd_port);
        @(posedge sys_clk) rd_ready <= 1'h1;
        @(posedge sys_clk) rd_ready <= 1'h0;
    endtask
    // ==========================================================
    // scenarios
    task s_pm();
        for (int i = 0; i < 3; i++) begin
            pm_op(1, dhm_fmt_t'(i), i == 1 ? 24'h800003 : 24'h000003, 48'hfedcba987654);
            pm_op(0, dhm_fmt_t'(i), i == 1 ? 24'h800003 : 24'h000003, 48'h0);
            get_rd(48'hfedcba987654 >> (8 * i) << (8 * i), 0);
            chk("pm sel", i == 1 ? 2'h1 : 2'h2, psel);
            chk("pm addr", i == 1 ? 24'h800003 : 24'h000003, prog_addr_bus);
        end
    endtask
    task s_dm();
        for (int b = 0; b < 4; b++) begin
            dm_op(1, DHM_FMT_32, b[0], (b << 28) | 2, 40'h9876543210);
            dlen = 0;
            dm_op(0, DHM_FMT_FULL, b[0], (b << 28) | 2, 40'h0);
            get_rd(40'h9876543200, 1);
            chk("dm sel", 4'(~(4'h1 << b)), dsel);
            chk("dm waits", data_wait[b] + 3, dlen);
            chk("dm addr", (b << 28) | 2, data_addr_bus);
        end
    endtask
    // fill until refused, drain
    task s_fill();
        dm_op(1, DHM_FMT_FULL, 1, 32'h5, 40'h55aa55aa55);
        repeat (33) dm_op(0, DHM_FMT_FULL, 1, 32'h5, 40'h0);
        repeat (20) @(negedge sys_clk);
        chk("full ready", 0, dm_req_ready);
        repeat (33) get_rd(48'h55aa55aa55, 1);
        @(negedge sys_clk) chk("empty", 0, rd_valid);
    endtask
    // pm floated, dm still works
    task s_float();
        @(posedge sys_clk) prog_port_float_n <= 1'h0;
        repeat (4) @(negedge sys_clk);
        chk("pm float oe", 0, prog_ctl_oe);
        chk("pm float ready", 0, pm_req_ready);
        dm_op(1, DHM_FMT_FULL, 1, 32'h7, 40'h1);
        chk("dm oe", 1, data_ctl_oe);
        @(posedge sys_clk) prog_port_float_n <= 1'h1;
    endtask
    task s_bus();
        @(posedge sys_clk) bus_request_n <= 1'h0;
        repeat (8) @(negedge sys_clk);
        chk("grant", 0, {bus_grant_n, prog_ctl_oe, data_ctl_oe, pm_req_ready});
        chk("halt", 1, core_halt);
        @(posedge sys_clk) bus_request_n <= 1'h1;
        repeat (8) @(negedge sys_clk);
        chk("release", 4'hf, {bus_grant_n, prog_ctl_oe, data_ctl_oe, pm_req_ready});
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'h0;
        s_pm();
        s_dm();
        s_fill();
        s_float();
        s_bus();
        wrap_up();
    end
endmodule
`default_nettype wire
